// File: obc_option_bytes.v
// Overview of operation
// - watchdog enable option bit set turns the watchdog timer on.
// - enabled watchdog expiry resets the device unless programming voltage is present.
// - watchdog enable bit clear keeps watchdog off whatever the pin voltage.
// - sensitivity bit clear: external interrupt only on falling edges.
// - sensitivity bit set: interrupt on falling edges and on low level.
// - serial bit order bit set shifts lsb first, clear shifts msb first.
// - serial rate code 00,01,10,11 divides oscillator by 64,32,16,8.
// - stop-to-halt bit set: stop instruction keeps oscillator, enters halt.
// - stop-to-halt bit clear: stop instruction stops oscillator, enters stop.
// - security bit set locks the eprom against external reading.
// - each port A option bit enables that pin's pullup and keyscan interrupt.
// - keyscan interrupts use the same sensitivity as the interrupt pin.
// - in bootloader mode all implemented option bits are readable and writable.
// - programmed option values take effect only after the next reset.
// - only the lower 13 address bits are decoded.
// - pulse bit settable only with latch already set; clearing latch clears pulse.
// - writing latch and pulse together while latch is clear sets latch only.
`timescale 1ns/1ps
`include "obc_consts.vh"

////////////////////////////////////////////////////////////////////////////////
module obc_option_bytes
#(
  parameter [`OBC_PULSE_CNT_W-1:0] PULSE_CYCLES = `OBC_PROG_PULSE_CYCLES
)
(
  // clock and reset
  input  wire       i_clk_sys,
  input  wire       i_rst_n,
  // cpu register access
  input  wire [15:0] i_addr,
  input  wire       i_wr,
  input  wire       i_rd,
  input  wire [7:0] i_wdata,
  output wire [7:0] o_rdata,
  // mode
  input  wire       i_boot_mode,
  // option eprom cell contents
  input  wire [7:0] i_nv_opt_one,
  input  wire [7:0] i_nv_opt_two,
  // option eprom programming
  output wire       o_prog_latch,
  output wire       o_prog_power,
  output wire       o_prog_sel_one,
  output wire       o_prog_sel_two,
  output wire [7:0] o_prog_data,
  output wire       o_prog_time_met,
  // watchdog
  input  wire       i_vpp_present,
  input  wire       i_wdog_expired,
  output wire       o_wdog_en,
  output wire       o_wdog_reset,
  // external interrupt pin
  input  wire       i_irq_n,
  output wire       o_irq_req,
  // port A
  input  wire [7:0] i_porta_n,
  output wire [7:0] o_porta_pullup_en,
  output wire [7:0] o_keyscan_req,
  // serial port options
  output wire       o_serial_lsb_first,
  output wire [1:0] o_serial_rate_code,
  output wire [6:0] o_serial_div,
  // stop instruction
  input  wire       i_stop_exec,
  input  wire       i_wake,
  output wire       o_enter_halt,
  output wire       o_enter_stop,
  output wire       o_osc_stop,
  // security and status
  output wire       o_eprom_locked,
  output wire       o_opt_loaded
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  reg  [7:0]                   ctrl_reg;
  reg  [7:0]                   ctrl_next;
  reg  [7:0]                   opt_one_reg;
  reg  [7:0]                   opt_two_reg;
  reg                          load_pend_reg;
  reg                          loaded_reg;
  reg  [7:0]                   rdata_reg;
  reg  [7:0]                   rdata_next;
  reg                          sel_one_reg;
  reg                          sel_two_reg;
  reg  [7:0]                   pdata_reg;
  reg  [`OBC_PULSE_CNT_W-1:0]  pulse_cnt_reg;
  reg                          time_met_reg;
  reg                          wdog_rst_reg;
  reg                          halt_reg;
  reg                          stop_reg;
  reg                          osc_stop_reg;
  reg  [6:0]                   div_next;
  reg  [6:0]                   div_reg;
  wire [`OBC_ADDR_BITS-1:0]    addr_lo;
  wire                         hit_ctrl;
  wire                         hit_one;
  wire                         hit_two;
  wire                         latch_bit;
  wire                         pulse_bit;
  wire                         halt_opt;
  wire                         opt_wr;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode
  // upper bits ignored
  assign addr_lo  = i_addr[`OBC_ADDR_BITS-1:0];
  assign hit_ctrl = (addr_lo == `OBC_ADDR_PROG_CTRL);
  assign hit_one  = (addr_lo == `OBC_ADDR_OPT_ONE);
  assign hit_two  = (addr_lo == `OBC_ADDR_OPT_TWO);
  assign latch_bit  = ctrl_reg[`OBC_CTRL_LATCH_POS];
  assign pulse_bit  = ctrl_reg[`OBC_CTRL_PULSE_POS];
  assign halt_opt   = opt_one_reg[`OBC_OPT_HALT_POS];
  // option byte writes only count in bootloader mode with the latch set
  // boot mode write
  assign opt_wr = i_wr & i_boot_mode & latch_bit & (hit_one | hit_two);

  ////////////////////////////////////////////////////////////////////////////////
  // program control next value, only latch and pulse bits exist
  always @*
  begin
    ctrl_next = ctrl_reg;
    if (i_wr && hit_ctrl)
    begin
      ctrl_next = `OBC_CTRL_RESET;
      ctrl_next[`OBC_CTRL_LATCH_POS] = i_wdata[`OBC_CTRL_LATCH_POS];
      ctrl_next[`OBC_CTRL_PULSE_POS] = i_wdata[`OBC_CTRL_PULSE_POS] & latch_bit
                                       & i_wdata[`OBC_CTRL_LATCH_POS];
    end
  end
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ctrl_reg <= `OBC_CTRL_RESET;
    else
      ctrl_reg <= ctrl_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // programming address and data latch, captured by the write after latch set
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sel_one_reg <= 1'b0;
      sel_two_reg <= 1'b0;
      pdata_reg   <= `OBC_OPT_RESET;
    end
    else if (!latch_bit)
    begin
      sel_one_reg <= 1'b0;
      sel_two_reg <= 1'b0;
    end
    else if (opt_wr)
    begin
      sel_one_reg <= hit_one;
      sel_two_reg <= hit_two;
      pdata_reg   <= hit_one ? (i_wdata & `OBC_OPT_ONE_MASK) : i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pulse length monitor; software owns the timing, this only reports it
  // minimum pulse time
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pulse_cnt_reg <= {`OBC_PULSE_CNT_W{1'b0}};
      time_met_reg  <= 1'b0;
    end
    else if (!pulse_bit)
    begin
      pulse_cnt_reg <= {`OBC_PULSE_CNT_W{1'b0}};
      time_met_reg  <= 1'b0;
    end
    else if (pulse_cnt_reg == PULSE_CYCLES - {{(`OBC_PULSE_CNT_W-1){1'b0}}, 1'b1})
      time_met_reg  <= 1'b1;
    else
      pulse_cnt_reg <= pulse_cnt_reg + {{(`OBC_PULSE_CNT_W-1){1'b0}}, 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // holding latches, loaded once right after reset release; the async reset
  // only clears them since cell values cannot be taken under reset
  // load at release only
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      opt_one_reg   <= `OBC_OPT_RESET;
      opt_two_reg   <= `OBC_OPT_RESET;
      load_pend_reg <= 1'b1;
      loaded_reg    <= 1'b0;
    end
    else if (load_pend_reg)
    begin
      opt_one_reg   <= i_nv_opt_one & `OBC_OPT_ONE_MASK;
      opt_two_reg   <= i_nv_opt_two;
      load_pend_reg <= 1'b0;
      loaded_reg    <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the read strobe; option bytes cannot be read
  // back while the latch bit holds the eprom bus for programming
  always @*
  begin
    rdata_next = 8'h00;
    if (hit_ctrl)
      rdata_next = ctrl_reg;
    else if (hit_one && !latch_bit)
      rdata_next = opt_one_reg;
    else if (hit_two && !latch_bit)
      rdata_next = opt_two_reg;
  end
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_reg <= 8'h00;
    else if (i_rd)
      rdata_reg <= rdata_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog reset request, blocked while programming voltage is on the pin
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      wdog_rst_reg <= 1'b0;
    else
      wdog_rst_reg <= o_wdog_en & i_wdog_expired & ~i_vpp_present;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // external interrupt pin detector
  obc_edge_level_sense #(.WIDTH (1))
  u_irq_sense
  (
    .i_clk_sys    (i_clk_sys),
    .i_rst_n      (i_rst_n),
    .i_pin_n      (i_irq_n),
    .i_enable     (loaded_reg),
    .i_level_mode (opt_one_reg[`OBC_OPT_LEVEL_POS]),
    .o_req        (o_irq_req)
  );
  obc_edge_level_sense #(.WIDTH (8))
  u_keyscan_sense
  (
    .i_clk_sys    (i_clk_sys),
    .i_rst_n      (i_rst_n),
    .i_pin_n      (i_porta_n),
    .i_enable     (opt_two_reg),
    .i_level_mode (opt_one_reg[`OBC_OPT_LEVEL_POS]),
    .o_req        (o_keyscan_req)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // serial master clock divide ratio
  always @*
  begin
    case ({opt_one_reg[`OBC_OPT_RATE_HI_POS], opt_one_reg[`OBC_OPT_RATE_LO_POS]})
      2'h0:    div_next = `OBC_DIV_CODE_00;
      2'h1:    div_next = `OBC_DIV_CODE_01;
      2'h2:    div_next = `OBC_DIV_CODE_10;
      2'h3:    div_next = `OBC_DIV_CODE_11;
      default: div_next = `OBC_DIV_CODE_00;
    endcase
  end
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      div_reg <= `OBC_DIV_CODE_00;
    else
      div_reg <= div_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // stop instruction handling; the oscillator stays stopped until a wake
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      halt_reg     <= 1'b0;
      stop_reg     <= 1'b0;
      osc_stop_reg <= 1'b0;
    end
    else
    begin
      halt_reg <= i_stop_exec & halt_opt;
      stop_reg <= i_stop_exec & ~halt_opt;
      if (i_stop_exec && !halt_opt)
        osc_stop_reg <= 1'b1;
      else if (i_wake)
        osc_stop_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  // watchdog on or off
  assign o_wdog_en          = opt_one_reg[`OBC_OPT_WDOG_POS];
  assign o_wdog_reset       = wdog_rst_reg;
  assign o_serial_lsb_first = opt_one_reg[`OBC_OPT_SERIAL_BIT_ORDER_BIT_POS];
  assign o_serial_rate_code = {opt_one_reg[`OBC_OPT_RATE_HI_POS], opt_one_reg[`OBC_OPT_RATE_LO_POS]};
  assign o_serial_div       = div_reg;
  assign o_eprom_locked     = opt_one_reg[`OBC_OPT_SECURE_POS];
  assign o_porta_pullup_en  = opt_two_reg;
  assign o_enter_halt       = halt_reg;
  assign o_enter_stop       = stop_reg;
  assign o_osc_stop         = osc_stop_reg;
  assign o_prog_latch       = latch_bit;
  assign o_prog_power       = pulse_bit;
  assign o_prog_sel_one     = sel_one_reg;
  assign o_prog_sel_two     = sel_two_reg;
  assign o_prog_data        = pdata_reg;
  assign o_prog_time_met    = time_met_reg;
  assign o_rdata            = rdata_reg;
  assign o_opt_loaded       = loaded_reg;

endmodule // obc_option_bytes

// File: obc_consts.vh
`ifndef OBC_CONSTS_VH
`define OBC_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// address decode, only the low address bits are seen
`define OBC_ADDR_BITS          13
`define OBC_ADDR_PROG_CTRL     13'h001c
`define OBC_ADDR_OPT_TWO       13'h1eff
`define OBC_ADDR_OPT_ONE       13'h1f00

////////////////////////////////////////////////////////////////////////////////
// eprom program control fields
`define OBC_CTRL_LATCH_POS     2
`define OBC_CTRL_PULSE_POS     0
`define OBC_CTRL_RESET         8'h00

////////////////////////////////////////////////////////////////////////////////
// option byte one fields
`define OBC_OPT_WDOG_POS       0
`define OBC_OPT_LEVEL_POS      1
`define OBC_OPT_SERIAL_BIT_ORDER_BIT_POS       2
`define OBC_OPT_RATE_LO_POS    3
`define OBC_OPT_RATE_HI_POS    4
`define OBC_OPT_HALT_POS       5
`define OBC_OPT_SECURE_POS     6
`define OBC_OPT_ONE_MASK       8'h7f
`define OBC_OPT_RESET          8'h00

////////////////////////////////////////////////////////////////////////////////
// serial master clock divide ratios per rate code
`define OBC_DIV_CODE_00        7'h40
`define OBC_DIV_CODE_01        7'h20
`define OBC_DIV_CODE_10        7'h10
`define OBC_DIV_CODE_11        7'h08

////////////////////////////////////////////////////////////////////////////////
// timing
`define OBC_CLK_PERIOD_NS      25
`define OBC_PROG_PULSE_TIME_US 4000
// pulse time in ns over the clock period, sized to the pulse counter
`define OBC_PROG_PULSE_CYCLES  18'h27100
`define OBC_PULSE_CNT_W        18

`endif

// File: obc_edge_level_sense.v
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// falling edge or edge-and-level request detector, one per active-low pin
module obc_edge_level_sense
#(
  parameter WIDTH = 1
)
(
  // clock and reset
  input  wire             i_clk_sys,
  input  wire             i_rst_n,
  // pins and controls
  input  wire [WIDTH-1:0] i_pin_n,
  input  wire [WIDTH-1:0] i_enable,
  input  wire             i_level_mode,
  // requests
  output wire [WIDTH-1:0] o_req
);

  reg [WIDTH-1:0] prev_reg;
  reg [WIDTH-1:0] req_reg;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_pin
      // idle level is high, so a pin held low at reset counts as an edge on the first cycle
      always @(posedge i_clk_sys or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          prev_reg[g] <= 1'b1;
          req_reg[g]  <= 1'b0;
        end
        else
        begin
          prev_reg[g] <= i_pin_n[g];
          req_reg[g]  <= i_enable[g] & ((prev_reg[g] & ~i_pin_n[g]) | (i_level_mode & ~i_pin_n[g]));
        end
      end
    end
  endgenerate

  assign o_req = req_reg;

endmodule // obc_edge_level_sense

// File: obc_option_bytes_properties.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module obc_option_bytes_chk
#(
  parameter [17:0] PULSE_CYCLES = 18'h00008
)
(
  // clock, reset and bus
  input wire        i_clk_sys,
  input wire        i_rst_n,
  input wire [15:0] i_addr,
  input wire        i_wr,
  input wire        i_rd,
  input wire [7:0]  i_wdata,
  input wire [7:0]  o_rdata,
  // option cells and programming
  input wire [7:0]  i_nv_opt_one,
  input wire [7:0]  i_nv_opt_two,
  input wire        o_prog_latch,
  input wire        o_prog_power,
  input wire        o_prog_time_met,
  // option consumers
  input wire        i_vpp_present,
  input wire        i_wdog_expired,
  input wire        o_wdog_en,
  input wire        o_wdog_reset,
  input wire        i_irq_n,
  input wire        o_irq_req,
  input wire [7:0]  i_porta_n,
  input wire [7:0]  o_porta_pullup_en,
  input wire [7:0]  o_keyscan_req,
  input wire        o_serial_lsb_first,
  input wire [1:0]  o_serial_rate_code,
  input wire [6:0]  o_serial_div,
  input wire        i_stop_exec,
  input wire        o_enter_halt,
  input wire        o_enter_stop,
  input wire        o_eprom_locked,
  input wire        o_opt_loaded
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // cycles the pulse bit has stood, wraps at its 18-bit width
  reg [17:0] pw_cnt;
  always @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n) pw_cnt <= 18'h00000;
    else pw_cnt <= o_prog_power ? pw_cnt + 18'h00001 : 18'h00000;

  // multi-step events
  sequence s_both_wr;
    i_wr && i_addr[12:0] == 13'h001c && i_wdata[2] && i_wdata[0] && !o_prog_latch;
  endsequence
  sequence s_fall;
    $past(o_opt_loaded) && $past(i_irq_n) && !i_irq_n;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  load_copy_a: assert property ($rose(o_opt_loaded) |-> o_wdog_en == $past(i_nv_opt_one[0])
    && o_eprom_locked == $past(i_nv_opt_one[6]) && o_porta_pullup_en == $past(i_nv_opt_two)
    && o_serial_lsb_first == $past(i_nv_opt_one[2]) && o_serial_rate_code == $past(i_nv_opt_one[4:3]))
    else $error("option latches differ from cells");
  opt_hold_a: assert property (o_opt_loaded && $past(o_opt_loaded) |-> $stable(o_porta_pullup_en)
    && $stable(o_wdog_en) && $stable(o_serial_rate_code)) else $error("live option changed");
  wdog_rst_a: assert property (o_wdog_reset == $past(o_wdog_en && i_wdog_expired && !i_vpp_present))
    else $error("watchdog reset wrong");
  div_code_a: assert property ($past(o_opt_loaded) |-> o_serial_div == (7'h40 >> $past(o_serial_rate_code)))
    else $error("serial divider wrong");
  stop_kind_a: assert property (o_opt_loaded && i_stop_exec |=> o_enter_halt != o_enter_stop)
    else $error("stop gives no single mode");
  pulse_need_a: assert property (o_prog_power |-> o_prog_latch && $past(o_prog_latch))
    else $error("pulse without latch");
  both_set_a: assert property (s_both_wr |=> o_prog_latch && !o_prog_power)
    else $error("latch and pulse set together");
  pulse_time_a: assert property ($rose(o_prog_time_met) |-> pw_cnt >= PULSE_CYCLES - 18'h00001)
    else $error("time met too early");
  irq_edge_a: assert property (s_fall |=> o_irq_req)
    else $error("falling edge missed");
  key_gate_a: assert property (o_opt_loaded |-> (o_keyscan_req & ($past(i_porta_n) | ~o_porta_pullup_en)) == 8'h00)
    else $error("keyscan request not allowed");
  ctrl_read_a: assert property (i_rd && i_addr[12:0] == 13'h001c |=>
    o_rdata == {5'h00, $past(o_prog_latch), 1'b0, $past(o_prog_power)}) else $error("control read wrong");
endmodule // obc_option_bytes_chk

// File: obc_nv_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// option eprom cells seen from the option block
module obc_nv_model
(
  // clock and preset
  input  wire       i_clk_sys,
  input  wire       i_load,
  input  wire [7:0] i_init_one,
  input  wire [7:0] i_init_two,
  // programming side
  input  wire       i_power,
  input  wire       i_time_met,
  input  wire       i_sel_one,
  input  wire       i_sel_two,
  input  wire [7:0] i_data,
  // cell contents
  output reg  [7:0] o_nv_one,
  output reg  [7:0] o_nv_two
);
  // cells after pulse
  // a pulse cut short leaves old data, as a real cell would
  always @(posedge i_clk_sys)
  begin
    if (i_load)
    begin
      o_nv_one <= i_init_one;
      o_nv_two <= i_init_two;
    end
    else if (i_power && i_time_met)
    begin
      if (i_sel_one) o_nv_one <= i_data;
      if (i_sel_two) o_nv_two <= i_data;
    end
  end
endmodule // obc_nv_model

// File: obc_option_bytes_tb_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module obc_option_bytes_tb_top;
  localparam [17:0] PC = 18'h00008;
  // design inputs
  reg        i_clk_sys = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_boot_mode = 1'b0;
  reg [15:0] i_addr = 16'h0000;
  reg [7:0]  i_wdata = 8'h00, i_porta_n = 8'hff, one = 8'h00, two = 8'h00, nw;
  reg        i_vpp_present = 1'b0, i_wdog_expired = 1'b0, i_irq_n = 1'b1, i_stop_exec = 1'b0, i_wake = 1'b0;
  reg        ld = 1'b0, rd_d = 1'b0;
  // design outputs
  wire [7:0] i_nv_opt_one, i_nv_opt_two, o_rdata, o_prog_data, o_porta_pullup_en, o_keyscan_req;
  wire [6:0] o_serial_div;
  wire [1:0] o_serial_rate_code;
  wire       o_prog_latch, o_prog_power, o_prog_sel_one, o_prog_sel_two, o_prog_time_met, o_wdog_en;
  wire       o_wdog_reset, o_irq_req, o_serial_lsb_first, o_enter_halt, o_enter_stop, o_osc_stop;
  wire       o_eprom_locked, o_opt_loaded;
  int        n_errors = 0, check_count = 0, na, nb, r;
  logic [7:0] exp_q[$];

  obc_option_bytes #(.PULSE_CYCLES(PC)) obc_option_bytes_i (.*);
  obc_nv_model obc_nv_model_i (.i_clk_sys, .i_load(ld), .i_init_one(one), .i_init_two(two),
    .i_power(o_prog_power), .i_time_met(o_prog_time_met), .i_sel_one(o_prog_sel_one),
    .i_sel_two(o_prog_sel_two), .i_data(o_prog_data), .o_nv_one(i_nv_opt_one), .o_nv_two(i_nv_opt_two));

  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  always #12.5 i_clk_sys = ~i_clk_sys;

  task complete_run;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // inputs move 2 ns after the edge
  task cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #2;
  endtask

  // one-cycle strobes with an idle cycle, so no strobe is set twice at once
  task wr(input [15:0] a, input [7:0] d);
    i_addr = a; i_wdata = d; i_wr = 1'b1; cyc(1); i_wr = 1'b0; cyc(1);
  endtask
  task rd(input [15:0] a, input [7:0] e);
    i_addr = a; i_rd = 1'b1; exp_q.push_back(e); cyc(1); i_rd = 1'b0; cyc(1);
  endtask
  task boot(input bit l);
    ld = l; i_rst_n = 1'b0; cyc(3); ld = 1'b0; i_rst_n = 1'b1; cyc(3);
  endtask

  // read data lands one edge after the strobe
  always @(posedge i_clk_sys)
  begin
    rd_d <= i_rd;
    if (rd_d) check(o_rdata, exp_q.pop_front());
  end

  // hang guard, far beyond the roughly 150 cycles of the run
  initial
  begin
    #100000;
    n_errors++;
    complete_run;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(22));
    for (int k = 0; k < 4; k++)
    begin
      r = $urandom;
      one = {r[7:6], k[0], k[1:0], r[2], k[1], k[0] ^ k[1]};
      two = {r[15:9], ~k[1]};
      boot(1'b1);
      check(8'(o_wdog_en), 8'(one[0]));
      check(8'(o_eprom_locked), 8'(one[6]));
      check(8'(o_serial_lsb_first), 8'(one[2]));
      check(8'(o_serial_div), 8'(8'h40 >> k));
      check(o_porta_pullup_en, two);
      rd(16'h1f00, one & 8'h7f);
      i_irq_n = 1'b0; i_porta_n = 8'hfe; na = 0; nb = 0;
      for (int t = 0; t < 7; t++)
      begin
        if (t == 4) begin i_irq_n = 1'b1; i_porta_n = 8'hff; end
        cyc(1); na += o_irq_req; nb += o_keyscan_req[0];
      end
      check(8'(na), one[1] ? 8'h04 : 8'h01);
      check(8'(nb), two[0] ? (one[1] ? 8'h04 : 8'h01) : 8'h00);
      for (int v = 0; v < 2; v++)
      begin
        i_vpp_present = v[0]; i_wdog_expired = 1'b1; na = 0;
        repeat (3) begin cyc(1); i_wdog_expired = 1'b0; na += o_wdog_reset; end
        check(8'(na), 8'(one[0] & ~v[0]));
      end
      i_vpp_present = 1'b0; i_stop_exec = 1'b1; cyc(1); i_stop_exec = 1'b0;
      check(8'(o_enter_halt), 8'(one[5]));
      check(8'(o_enter_stop), 8'(!one[5]));
      cyc(1);
      check(8'(o_osc_stop), 8'(!one[5]));
      i_wake = 1'b1; cyc(1); i_wake = 1'b0; cyc(1);
      check(8'(o_osc_stop), 8'h00);
    end
    // programming of option byte two in boot mode
    nw = $urandom; i_boot_mode = 1'b1;
    wr(16'h001c, 8'h01); rd(16'h001c, 8'h00);
    wr(16'he01c, 8'h05); rd(16'h001c, 8'h04);
    rd(16'h1eff, 8'h00);
    wr(16'hfeff, nw);
    check(o_prog_data, nw);
    check(8'(o_prog_sel_two), 8'h01);
    wr(16'h001c, 8'h05); rd(16'h001c, 8'h05);
    na = 0;
    while (o_prog_time_met !== 1'b1 && na < 40) begin cyc(1); na++; end
    check(8'(o_prog_time_met), 8'h01);
    wr(16'h001c, 8'h00); rd(16'h001c, 8'h00);
    check(o_porta_pullup_en, two);
    boot(1'b0);
    check(o_porta_pullup_en, nw);
    // option one target in boot mode, unimplemented top bit masked
    wr(16'h001c, 8'h04); wr(16'h1f00, 8'hff);
    check(o_prog_data, 8'h7f);
    check(8'(o_prog_sel_one), 8'h01);
    wr(16'h001c, 8'h00);
    check(8'(o_prog_sel_one), 8'h00);
    i_boot_mode = 1'b0;
    wr(16'h001c, 8'h04); wr(16'h1f00, 8'h11);
    check(8'(o_prog_sel_one), 8'h00);
    wr(16'h001c, 8'h00);
    rd(16'h1eff, nw);
    rd(16'h0123, 8'h00);
    cyc(2);
    complete_run;
  end
endmodule // obc_option_bytes_tb_top

bind obc_option_bytes obc_option_bytes_chk #(.PULSE_CYCLES(PULSE_CYCLES)) obc_option_bytes_chk_i (.*);
